/* design/pbtt_pkg.sv */
package pbtt_pkg;

    // ------------------------------------------------------------------
    // clock and millisecond timebase
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_TIME_NS    = 1000000;
    localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------------
    localparam int unsigned RTY_W  = 3;
    localparam int unsigned ROT_W  = 24;
    localparam int unsigned SLOT_W = 14;
    localparam int unsigned GAP_W  = 7;
    localparam int unsigned QUI_W  = 8;
    localparam int unsigned SET_W  = 9;
    localparam int unsigned TSDR_W = 10;
    localparam int unsigned IDLE_W = 11;
    localparam int unsigned CYC_W  = 16;
    localparam int unsigned MSC_W  = 17;
    localparam int unsigned DIV_W  = 16;

    // ------------------------------------------------------------------
    // limits and reset values (bit times, except retry counts, gap factor and cycle time in ms)
    // ------------------------------------------------------------------
    localparam logic [RTY_W-1:0]  RTY_MIN      = 3'h1;
    localparam logic [RTY_W-1:0]  RTY_MAX      = 3'h5;
    localparam logic [RTY_W-1:0]  TOK_RTY_RST  = 3'h3;
    localparam logic [RTY_W-1:0]  MSG_RTY_RST  = 3'h1;
    localparam logic [ROT_W-1:0]  ROT_RST      = 24'h005208;
    localparam logic [SLOT_W-1:0] SLOT_MIN     = 14'h0025;
    localparam logic [SLOT_W-1:0] SLOT_RST     = 14'h0064;
    localparam logic [GAP_W-1:0]  GAP_MIN      = 7'h01;
    localparam logic [GAP_W-1:0]  GAP_MAX      = 7'h64;
    localparam logic [GAP_W-1:0]  GAP_RST      = 7'h0a;
    localparam logic [QUI_W-1:0]  QUI_RST      = 8'h00;
    localparam logic [SET_W-1:0]  SET_MIN      = 9'h001;
    localparam logic [SET_W-1:0]  SET_MAX      = 9'h1ee;
    localparam logic [SET_W-1:0]  SET_RST      = 9'h001;
    localparam logic [TSDR_W-1:0] TSDR_MIN     = 10'h00b;
    localparam logic [TSDR_W-1:0] TSDR_RST     = 10'h00b;
    localparam logic [CYC_W-1:0]  CYC_RST      = 16'h0064;
    localparam logic [IDLE_W-1:0] SYN_TIME     = 11'h021;
    localparam logic [IDLE_W-1:0] SM_BASE      = 11'h002;

    // ------------------------------------------------------------------
    // reply supervision states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_WAIT_MSG = 3'b010,
        ST_WAIT_TOK = 3'b100
    } pbtt_state_t;

endpackage : pbtt_pkg

/* design/pbtt_bit_tick.sv */
`timescale 1ns/100ps
module pbtt_bit_tick (
    input  wire logic                        mclk_in,
    input  wire logic                        rst_b_in,
    input  wire logic [pbtt_pkg::DIV_W-1:0]  bit_div_in,
    output logic                             tick_out
);

    logic [pbtt_pkg::DIV_W-1:0] cnt_q;
    logic [pbtt_pkg::DIV_W-1:0] cnt_d;
    wire  [pbtt_pkg::DIV_W-1:0] div_m1;
    wire                        last;

    // a divisor of zero behaves as one so the tick never stalls
    assign div_m1 = (bit_div_in == 16'h0000) ? 16'h0000
                                             : bit_div_in - 16'h0001;
    assign last   = (cnt_q >= div_m1);
    assign cnt_d  = last ? 16'h0000 : cnt_q + 16'h0001;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            cnt_q    <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            tick_out <= last;
        end
    end

    property p_tick_spacing;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (tick_out && bit_div_in > 16'h0001 && $stable(bit_div_in))
            |=> !tick_out;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("bit tick repeated inside one bit period");

endmodule : pbtt_bit_tick

/* design/pbtt_token_timing.sv */
`timescale 1ns/100ps
module pbtt_token_timing #(
    parameter int unsigned MS_CYCLES_P = pbtt_pkg::MS_CYCLES
) (
    input  wire logic                         mclk_in,
    input  wire logic                         rst_b_in,
    input  wire logic [pbtt_pkg::DIV_W-1:0]   bit_div_in,
    input  wire logic                         cfg_load_in,
    input  wire logic [pbtt_pkg::RTY_W-1:0]   tok_retry_lim_in,
    input  wire logic [pbtt_pkg::RTY_W-1:0]   msg_retry_lim_in,
    input  wire logic [pbtt_pkg::ROT_W-1:0]   target_rotation_time_in,
    input  wire logic [pbtt_pkg::SLOT_W-1:0]  reply_slot_time_in,
    input  wire logic [pbtt_pkg::GAP_W-1:0]   gap_factor_in,
    input  wire logic [pbtt_pkg::QUI_W-1:0]   quiet_time_in,
    input  wire logic [pbtt_pkg::SET_W-1:0]   setup_time_in,
    input  wire logic [pbtt_pkg::TSDR_W-1:0]  min_resp_delay_in,
    input  wire logic [pbtt_pkg::CYC_W-1:0]   cycle_ms_in,
    input  wire logic [pbtt_pkg::CYC_W-1:0]   cycle_extend_ms_in,
    input  wire logic                         msg_sent_in,
    input  wire logic                         token_sent_in,
    input  wire logic                         reply_start_in,
    input  wire logic                         ack_token_rx_in,
    input  wire logic                         token_rx_in,
    input  wire logic                         gap_result_vld_in,
    input  wire logic [1:0]                   gap_result_in,
    output logic                              slot_timeout_out,
    output logic                              msg_repeat_out,
    output logic                              msg_fail_out,
    output logic                              token_repeat_out,
    output logic                              station_absent_out,
    output logic                              rx_enable_out,
    output logic                              idle_done_out,
    output logic [pbtt_pkg::IDLE_W-1:0]       idle_time_after_ack_out,
    output logic                              rotation_overrun_out,
    output logic                              gap_check_due_out,
    output logic [1:0]                        gap_status_out,
    output logic                              cycle_start_out,
    output logic                              cfg_error_out
);

    // ------------------------------------------------------------------
    // configuration store
    // ------------------------------------------------------------------
    logic [pbtt_pkg::RTY_W-1:0]  tok_lim_q;
    logic [pbtt_pkg::RTY_W-1:0]  msg_lim_q;
    logic [pbtt_pkg::ROT_W-1:0]  rot_lim_q;
    logic [pbtt_pkg::SLOT_W-1:0] slot_q;
    logic [pbtt_pkg::GAP_W-1:0]  gap_q;
    logic [pbtt_pkg::QUI_W-1:0]  qui_q;
    logic [pbtt_pkg::SET_W-1:0]  set_q;
    logic [pbtt_pkg::TSDR_W-1:0] tsdr_q;
    logic [pbtt_pkg::CYC_W-1:0]  cyc_q;
    logic [pbtt_pkg::CYC_W-1:0]  ext_q;
    pbtt_pkg::pbtt_state_t       state_q;
    pbtt_pkg::pbtt_state_t       state_d;
    wire                         load_ok;

    // loading mid-reply would move the goalposts of a running timeout
    assign load_ok = cfg_load_in && (state_q == pbtt_pkg::ST_IDLE);

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            tok_lim_q <= pbtt_pkg::TOK_RTY_RST;
            msg_lim_q <= pbtt_pkg::MSG_RTY_RST;
            rot_lim_q <= pbtt_pkg::ROT_RST;
            slot_q    <= pbtt_pkg::SLOT_RST;
            gap_q     <= pbtt_pkg::GAP_RST;
            qui_q     <= pbtt_pkg::QUI_RST;
            set_q     <= pbtt_pkg::SET_RST;
            tsdr_q    <= pbtt_pkg::TSDR_RST;
            cyc_q     <= pbtt_pkg::CYC_RST;
            ext_q     <= 16'h0000;
        end else if (load_ok) begin
            tok_lim_q <= tok_retry_lim_in;
            msg_lim_q <= msg_retry_lim_in;
            rot_lim_q <= target_rotation_time_in;
            slot_q    <= reply_slot_time_in;
            gap_q     <= gap_factor_in;
            qui_q     <= quiet_time_in;
            set_q     <= setup_time_in;
            tsdr_q    <= min_resp_delay_in;
            cyc_q     <= cycle_ms_in;
            ext_q     <= cycle_extend_ms_in;
        end
    end

    // ------------------------------------------------------------------
    // range checks
    // ------------------------------------------------------------------
    wire cfg_bad;
    assign cfg_bad = (tok_lim_q < pbtt_pkg::RTY_MIN)
                  || (tok_lim_q > pbtt_pkg::RTY_MAX)
                  || (msg_lim_q < pbtt_pkg::RTY_MIN)
                  || (msg_lim_q > pbtt_pkg::RTY_MAX)
                  || (slot_q < pbtt_pkg::SLOT_MIN)
                  || (gap_q < pbtt_pkg::GAP_MIN)
                  || (gap_q > pbtt_pkg::GAP_MAX)
                  || ({2'h0, qui_q} >= tsdr_q)
                  || (set_q < pbtt_pkg::SET_MIN)
                  || (set_q > pbtt_pkg::SET_MAX)
                  || (tsdr_q < pbtt_pkg::TSDR_MIN)
                  || (cyc_q == 16'h0000);

    // ------------------------------------------------------------------
    // bit timebase
    // ------------------------------------------------------------------
    logic tick;

    pbtt_bit_tick u_tick (
        .mclk_in    (mclk_in),
        .rst_b_in   (rst_b_in),
        .bit_div_in (bit_div_in),
        .tick_out   (tick)
    );

    // ------------------------------------------------------------------
    // reply supervision and retries
    // ------------------------------------------------------------------
    logic [pbtt_pkg::SLOT_W-1:0] slot_cnt_q;
    logic [pbtt_pkg::RTY_W-1:0]  retry_q;
    wire                         waiting;
    wire                         timeout;
    wire                         give_up;
    wire                         is_tok;
    wire  [pbtt_pkg::RTY_W-1:0]  cur_lim;
    wire  [pbtt_pkg::SLOT_W-1:0] slot_cnt_d;
    wire  [pbtt_pkg::RTY_W-1:0]  retry_d;

    assign waiting = (state_q != pbtt_pkg::ST_IDLE);
    assign is_tok  = (state_q == pbtt_pkg::ST_WAIT_TOK);
    assign cur_lim = is_tok ? tok_lim_q : msg_lim_q;
    // a reply starting in the timeout cycle wins over the timeout
    assign timeout = waiting && tick && !reply_start_in
                  && (slot_cnt_q >= slot_q - 14'h0001);
    assign give_up = timeout && (retry_q >= cur_lim);
    assign slot_cnt_d = !waiting ? 14'h0000
                      : (tick ? slot_cnt_q + 14'h0001 : slot_cnt_q);
    assign retry_d = ((waiting && reply_start_in) || give_up) ? 3'h0
                   : (timeout ? retry_q + 3'h1 : retry_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            pbtt_pkg::ST_IDLE: begin
                if (msg_sent_in) begin
                    state_d = pbtt_pkg::ST_WAIT_MSG;
                end else if (token_sent_in) begin
                    state_d = pbtt_pkg::ST_WAIT_TOK;
                end
            end
            pbtt_pkg::ST_WAIT_MSG,
            pbtt_pkg::ST_WAIT_TOK: begin
                if (reply_start_in || timeout) begin
                    state_d = pbtt_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = pbtt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            state_q            <= pbtt_pkg::ST_IDLE;
            slot_cnt_q         <= 14'h0000;
            retry_q            <= 3'h0;
            slot_timeout_out   <= 1'b0;
            msg_repeat_out     <= 1'b0;
            msg_fail_out       <= 1'b0;
            token_repeat_out   <= 1'b0;
            station_absent_out <= 1'b0;
        end else begin
            state_q            <= state_d;
            slot_cnt_q         <= slot_cnt_d;
            retry_q            <= retry_d;
            slot_timeout_out   <= timeout;
            msg_repeat_out     <= timeout && !is_tok && !give_up;
            msg_fail_out       <= give_up && !is_tok;
            token_repeat_out   <= timeout && is_tok && !give_up;
            station_absent_out <= give_up && is_tok;
        end
    end

    // ------------------------------------------------------------------
    // quiet time, idle time and rotation timer
    // ------------------------------------------------------------------
    logic [pbtt_pkg::QUI_W-1:0]  qui_cnt_q;
    logic [pbtt_pkg::IDLE_W-1:0] idle_cnt_q;
    logic [pbtt_pkg::ROT_W-1:0]  rot_cnt_q;
    wire                         sent;
    wire  [pbtt_pkg::IDLE_W-1:0] sm_sum;
    wire  [pbtt_pkg::IDLE_W-1:0] idle_calc;
    wire                         qui_end;
    wire                         idle_end;

    assign sent     = msg_sent_in || token_sent_in;
    assign sm_sum   = pbtt_pkg::SYN_TIME + pbtt_pkg::SM_BASE
                    + {1'b0, set_q, 1'b0} + {3'h0, qui_q};
    assign idle_calc = (sm_sum > {1'b0, tsdr_q}) ? sm_sum
                                                 : {1'b0, tsdr_q};
    assign qui_end  = tick && (qui_cnt_q >= qui_q - 8'h01);
    assign idle_end = tick && (idle_cnt_q >= idle_calc - 11'h001);

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            qui_cnt_q     <= 8'h00;
            rx_enable_out <= 1'b1;
        end else if (sent) begin
            qui_cnt_q     <= 8'h00;
            rx_enable_out <= (qui_q == 8'h00);
        end else if (!rx_enable_out && tick) begin
            qui_cnt_q     <= qui_cnt_q + 8'h01;
            rx_enable_out <= qui_end;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            idle_cnt_q              <= 11'h000;
            idle_done_out           <= 1'b1;
            idle_time_after_ack_out <= 11'h000;
        end else begin
            idle_time_after_ack_out <= idle_calc;
            if (ack_token_rx_in) begin
                idle_cnt_q    <= 11'h000;
                idle_done_out <= 1'b0;
            end else if (!idle_done_out && tick) begin
                idle_cnt_q    <= idle_cnt_q + 11'h001;
                idle_done_out <= idle_end;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            rot_cnt_q            <= 24'h000000;
            rotation_overrun_out <= 1'b0;
        end else if (token_rx_in) begin
            rot_cnt_q            <= 24'h000000;
            rotation_overrun_out <= 1'b0;
        end else begin
            // saturates so an orphaned token cannot wrap to "on time"
            if (tick && rot_cnt_q != 24'hffffff) begin
                rot_cnt_q <= rot_cnt_q + 24'h000001;
            end
            rotation_overrun_out <= rotation_overrun_out
                                 || (rot_cnt_q >= rot_lim_q);
        end
    end

    // ------------------------------------------------------------------
    // gap check pacing and cycle period
    // ------------------------------------------------------------------
    localparam logic [pbtt_pkg::MSC_W-1:0] MS_LAST =
        pbtt_pkg::MSC_W'(MS_CYCLES_P - 1);

    logic [pbtt_pkg::GAP_W-1:0] gap_cnt_q;
    logic [pbtt_pkg::MSC_W-1:0] ms_cnt_q;
    logic [pbtt_pkg::MSC_W-1:0] cyc_cnt_q;
    logic                       ms_tick_q;
    wire                        gap_due;
    wire  [pbtt_pkg::MSC_W-1:0] period;
    wire                        cyc_end;

    assign gap_due = token_rx_in && (gap_cnt_q >= gap_q - 7'h01);
    assign period  = {1'b0, cyc_q} + {1'b0, ext_q};
    assign cyc_end = ms_tick_q && (cyc_cnt_q >= period - 17'h00001);

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            gap_cnt_q         <= 7'h00;
            gap_check_due_out <= 1'b0;
            gap_status_out    <= 2'h0;
            cfg_error_out     <= 1'b0;
        end else begin
            if (token_rx_in) begin
                gap_cnt_q <= gap_due ? 7'h00 : gap_cnt_q + 7'h01;
            end
            gap_check_due_out <= gap_due;
            if (gap_result_vld_in) begin
                gap_status_out <= gap_result_in;
            end
            cfg_error_out <= cfg_bad;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            ms_cnt_q        <= 17'h00000;
            ms_tick_q       <= 1'b0;
            cyc_cnt_q       <= 17'h00000;
            cycle_start_out <= 1'b0;
        end else begin
            ms_cnt_q  <= (ms_cnt_q >= MS_LAST) ? 17'h00000
                                               : ms_cnt_q + 17'h00001;
            ms_tick_q <= (ms_cnt_q >= MS_LAST);
            if (ms_tick_q) begin
                cyc_cnt_q <= cyc_end ? 17'h00000 : cyc_cnt_q + 17'h00001;
            end
            cycle_start_out <= cyc_end;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_slot_timeout;
        @(posedge mclk_in) disable iff (!rst_b_in)
        slot_timeout_out |-> ($past(slot_cnt_q) >= $past(slot_q) - 14'h0001)
                             && state_q == pbtt_pkg::ST_IDLE;
    endproperty
    a_slot_timeout: assert property (p_slot_timeout)
        else $error("slot timeout before slot time elapsed");

    property p_msg_limit;
        @(posedge mclk_in) disable iff (!rst_b_in)
        msg_repeat_out |-> $past(retry_q) < $past(msg_lim_q)
                           && retry_q == $past(retry_q) + 3'h1;
    endproperty
    a_msg_limit: assert property (p_msg_limit)
        else $error("telegram repeated past its limit");

    property p_tok_limit;
        @(posedge mclk_in) disable iff (!rst_b_in)
        station_absent_out |-> $past(retry_q) >= $past(tok_lim_q)
                               && retry_q == 3'h0;
    endproperty
    a_tok_limit: assert property (p_tok_limit)
        else $error("station declared absent before retries ran out");

    property p_rotation;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (rot_cnt_q >= rot_lim_q && !token_rx_in) |=> rotation_overrun_out;
    endproperty
    a_rotation: assert property (p_rotation)
        else $error("rotation overrun not flagged");

    property p_quiet;
        @(posedge mclk_in) disable iff (!rst_b_in)
        (sent && qui_q != 8'h00) |=> !rx_enable_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("receiver enabled inside quiet time");

    property p_idle_wait;
        @(posedge mclk_in) disable iff (!rst_b_in)
        ack_token_rx_in |=> !idle_done_out
                            && idle_time_after_ack_out >= {1'b0, tsdr_q};
    endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("idle time not enforced after ack or token");

    property p_gap_due;
        @(posedge mclk_in) disable iff (!rst_b_in)
        gap_check_due_out |-> $past(token_rx_in) && gap_cnt_q == 7'h00;
    endproperty
    a_gap_due: assert property (p_gap_due)
        else $error("gap check requested without token rotation");

    property p_cycle;
        @(posedge mclk_in) disable iff (!rst_b_in)
        cycle_start_out |-> $past(ms_tick_q) && cyc_cnt_q == 17'h00000;
    endproperty
    a_cycle: assert property (p_cycle)
        else $error("cycle start off the millisecond grid");

endmodule : pbtt_token_timing

/* testbench/pbtt_slave_model.sv */
`timescale 1ns/100ps
module pbtt_slave_model (
    input  wire logic       mclk_in,
    input  wire logic       req_in,
    input  wire logic       answer_in,
    input  wire logic [9:0] delay_in,
    output logic            reply_start_out
);
    int cnt = -1;
    // a silent slave never answers, so the master must time out
    always @(posedge mclk_in) begin
        reply_start_out <= 1'b0;
        if (req_in && answer_in) begin
            cnt <= delay_in;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            reply_start_out <= 1'b1;
            cnt <= -1;
        end
    end
endmodule : pbtt_slave_model

/* testbench/pbtt_token_timing_tb.sv */
`timescale 1ns/100ps
module pbtt_token_timing_tb;
    logic        mclk_in = 1'b0, rst_b_in = 1'b0, cfg_load_in = 1'b0;
    logic        msg_sent_in = 1'b0, token_sent_in = 1'b0, answer = 1'b0;
    logic        ack_token_rx_in = 1'b0, token_rx_in = 1'b0;
    logic        gap_result_vld_in = 1'b0, reply_start_in;
    logic [15:0] bit_div_in = 16'h1, cycle_ms_in = 16'h1;
    logic [15:0] cycle_extend_ms_in = 16'h1;
    logic [2:0]  tok_retry_lim_in = 3'h3, msg_retry_lim_in = 3'h1;
    logic [23:0] target_rotation_time_in = 24'h64;
    logic [13:0] reply_slot_time_in = 14'h25;
    logic [6:0]  gap_factor_in = 7'h2;
    logic [7:0]  quiet_time_in = 8'h0;
    logic [8:0]  setup_time_in = 9'h1;
    logic [9:0]  min_resp_delay_in = 10'hb;
    logic [1:0]  gap_result_in = 2'h0, gap_status_out;
    logic [10:0] idle_time_after_ack_out;
    logic        slot_timeout_out, msg_repeat_out, msg_fail_out;
    logic        token_repeat_out, station_absent_out, rx_enable_out;
    logic        idle_done_out, rotation_overrun_out, gap_check_due_out;
    logic        cycle_start_out, cfg_error_out, rep, fail;
    int          errors = 0, check_count = 0, n, lim, e, hits;
    localparam int MS = 20;

    always #5 mclk_in = ~mclk_in;

    pbtt_token_timing #(.MS_CYCLES_P(MS)) dut (.*);
    pbtt_slave_model slave (.mclk_in(mclk_in), .req_in(msg_sent_in),
        .answer_in(answer), .delay_in(min_resp_delay_in),
        .reply_start_out(reply_start_in));

    function automatic int idle_exp(int st, int q, int md);
        return (35 + 2 * st + q > md) ? 35 + 2 * st + q : md;
    endfunction : idle_exp

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    task automatic wait_hi(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            end_of_test();
        end
    endtask : wait_hi

    task automatic cfg(input logic [13:0] sl, input logic [7:0] q,
                       input logic [8:0] st, input logic [9:0] md);
        reply_slot_time_in = sl;
        quiet_time_in = q;
        setup_time_in = st;
        min_resp_delay_in = md;
        pulse(cfg_load_in);
        tick(1);
    endtask : cfg

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    initial begin
        #500000;
        errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(61093));
        tick(8);
        rst_b_in = 1'b1;
        tick(2);
        check(idle_time_after_ack_out, 24'h25);
        check(rx_enable_out, 24'h1);
        for (int i = 0; i < 3; i++) begin
            cfg(i == 0 ? 14'h24 : 14'h25, i == 1 ? 8'hb : 8'h0,
                i == 2 ? 9'h1ef : 9'h1, 10'hb);
            check(cfg_error_out, 24'h1);
        end
        $display("test config done");
        for (int k = 0; k < 2; k++) begin
            lim = k ? 1 + $urandom % 5 : 5;
            e = k ? 37 + $urandom % 20 : 37;
            // slower bit clock on the token pass run exercises the divider
            bit_div_in = k ? 16'(2 + $urandom % 3) : 16'h1;
            hits = e * bit_div_in;
            tok_retry_lim_in = lim[2:0];
            msg_retry_lim_in = lim[2:0];
            cfg(e[13:0], 8'h0, 9'h1, 10'hb);
            check(cfg_error_out, 24'h0);
            for (int i = 0; i <= lim; i++) begin
                if (k) pulse(token_sent_in);
                else pulse(msg_sent_in);
                wait_hi(slot_timeout_out);
                rep = k ? token_repeat_out : msg_repeat_out;
                fail = k ? station_absent_out : msg_fail_out;
                check(n > hits - bit_div_in && n <= hits, 24'h1);
                check(rep, i < lim);
                check(fail, i == lim);
            end
        end
        bit_div_in = 16'h1;
        $display("test retry done");
        answer = 1'b1;
        cfg(14'h25, 8'h7, 9'h1, 10'hb);
        pulse(msg_sent_in);
        check(rx_enable_out, 24'h0);
        wait_hi(rx_enable_out);
        check(n inside {[6:8]}, 24'h1);
        hits = 0;
        repeat (50) begin
            tick(1);
            hits += slot_timeout_out;
        end
        check(hits, 24'h0);
        answer = 1'b0;
        $display("test reply done");
        for (int i = 0; i < 4; i++) begin
            lim = i ? 11 + $urandom % 1013 : 1023;
            n = i ? $urandom % 256 : 0;
            e = i ? 1 + $urandom % 494 : 1;
            if (n >= lim) n = lim - 1;
            cfg(14'h25, n[7:0], e[8:0], lim[9:0]);
            e = idle_exp(e, n, lim);
            check(idle_time_after_ack_out, e);
            pulse(ack_token_rx_in);
            check(idle_done_out, 24'h0);
            wait_hi(idle_done_out);
            check(n inside {[e - 1:e + 1]}, 24'h1);
        end
        $display("test idle done");
        e = 64 + $urandom % 64;
        target_rotation_time_in = e[23:0];
        cycle_ms_in = 16'h1 + 16'($urandom % 3);
        cfg(14'h25, 8'h0, 9'h1, 10'hb);
        hits = 0;
        repeat (4) begin
            pulse(token_rx_in);
            repeat (3) begin
                hits += gap_check_due_out;
                tick(1);
            end
        end
        check(hits, 24'h2);
        pulse(token_rx_in);
        check(rotation_overrun_out, 24'h0);
        wait_hi(rotation_overrun_out);
        check(n inside {[e - 2:e + 2]}, 24'h1);
        // never the reset code, so a dead latch cannot pass
        gap_result_in = 2'h1 + 2'($urandom % 3);
        pulse(gap_result_vld_in);
        tick(1);
        check(gap_status_out, gap_result_in);
        wait_hi(cycle_start_out);
        tick(1);
        wait_hi(cycle_start_out);
        check(n + 1, (cycle_ms_in + cycle_extend_ms_in) * MS);
        $display("test rotation gap cycle done");
        end_of_test();
    end
endmodule : pbtt_token_timing_tb
